// ---- logic/gtimer_pkg.sv ----
// shared constants, modes and helpers of the dual half timer
package gtimer_pkg;
	// ********************************************************
	// register offsets
	// ********************************************************
	localparam logic [7:0] OFF_CFG = 8'h00;
	localparam logic [7:0] OFF_HALF_MODE = 8'h04;
	localparam logic [7:0] OFF_CTRL = 8'h08;
	localparam logic [7:0] OFF_LOAD_FIRST = 8'h0C;
	localparam logic [7:0] OFF_LOAD_SECOND = 8'h10;
	localparam logic [7:0] OFF_MATCH_FIRST = 8'h14;
	localparam logic [7:0] OFF_MATCH_SECOND = 8'h18;
	localparam logic [7:0] OFF_VALUE_FIRST = 8'h1C;
	localparam logic [7:0] OFF_VALUE_SECOND = 8'h20;
	localparam logic [7:0] OFF_INT_RAW = 8'h24;
	localparam logic [7:0] OFF_INT_MASKED = 8'h28;
	localparam logic [7:0] OFF_INT_ENABLE = 8'h2C;
	localparam logic [7:0] OFF_INT_CLEAR = 8'h30;
	// ********************************************************
	// field positions and reset values
	// ********************************************************
	localparam int HALF_MODE_SECOND_LO = 4;
	localparam int CTL_EN = 0;
	localparam int CTL_INV = 1;
	localparam int CTL_STALL = 2;
	localparam int CTL_TRIG = 3;
	localparam int CTL_EDGE_LO = 4;
	localparam int CTL_STRIDE = 8;
	localparam int CTL_RTC_EN = 16;
	localparam int INT_TIMEOUT = 0;
	localparam int INT_CAP_MATCH = 1;
	localparam int INT_CAP_EVENT = 2;
	localparam int INT_RTC_MATCH = 3;
	localparam int INT_STRIDE = 8;
	localparam int INT_W = 11;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [1:0] EDGE_RISE = 2'h0;
	localparam logic [1:0] EDGE_FALL = 2'h1;
	// ********************************************************
	// timing
	// ********************************************************
	localparam int unsigned RTC_INPUT_HZ = 32768;
	localparam int unsigned RTC_TICK_S = 1;
	localparam int unsigned RTC_DIVIDE = RTC_INPUT_HZ * RTC_TICK_S;
	// ********************************************************
	// modes
	// ********************************************************
	typedef enum logic [3:0] {CFG_WIDE_ONE_SHOT = 4'h1, CFG_WIDE_PERIODIC = 4'h2,
		CFG_WIDE_RTC = 4'h4, CFG_HALF_PAIR = 4'h8} top_mode_type;
	typedef enum logic [4:0] {HALF_ONE_SHOT = 5'h01, HALF_PERIODIC = 5'h02,
		HALF_EDGE_COUNT = 5'h04, HALF_EDGE_TIME = 5'h08, HALF_PWM = 5'h10} half_mode_type;
	function automatic top_mode_type decodeTop(input logic [1:0] f);
		case (f)
			2'h0: decodeTop = CFG_WIDE_ONE_SHOT;
			2'h1: decodeTop = CFG_WIDE_PERIODIC;
			2'h2: decodeTop = CFG_WIDE_RTC;
			default: decodeTop = CFG_HALF_PAIR;
		endcase
	endfunction
	function automatic half_mode_type decodeHalf(input logic [2:0] f);
		case (f)
			3'h1: decodeHalf = HALF_PERIODIC;
			3'h2: decodeHalf = HALF_EDGE_COUNT;
			3'h3: decodeHalf = HALF_EDGE_TIME;
			3'h4: decodeHalf = HALF_PWM;
			default: decodeHalf = HALF_ONE_SHOT;
		endcase
	endfunction
endpackage

// ---- logic/half_ctrl_if.sv ----
// control and status bundle between the top and one 16-bit half
`timescale 1ns/1ps
interface half_ctrl_if;
	logic clockEn;
	logic debugHalt;
	logic [2:0] modeSel;
	logic enable;
	logic invert;
	logic stall;
	logic trigEn;
	logic [1:0] edgeSel;
	logic [15:0] loadVal;
	logic [15:0] matchVal;
	logic [15:0] shown;
	logic timeout;
	logic capEvent;
	logic capMatch;
	logic pinOut;
	logic pinOe;
	logic trigger;
	modport ctrl (output clockEn, debugHalt, modeSel, enable, invert, stall, trigEn, edgeSel,
		loadVal, matchVal, input shown, timeout, capEvent, capMatch, pinOut, pinOe, trigger);
	modport half (input clockEn, debugHalt, modeSel, enable, invert, stall, trigEn, edgeSel,
		loadVal, matchVal, output shown, timeout, capEvent, capMatch, pinOut, pinOe, trigger);
endinterface

// ---- logic/rtc_prescaler.sv ----
// divides the slow external clock input down to a one second tick
`timescale 1ns/1ps
module rtc_prescaler #(
	parameter int unsigned DIVIDE = gtimer_pkg::RTC_DIVIDE
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic clockEn,
	input wire logic enable,
	input wire logic slowIn,
	output logic tick
);
	localparam int CNT_W = (DIVIDE > 1) ? $clog2(DIVIDE) : 1;
	logic slowPrev_q;
	logic [CNT_W-1:0] count_q;
	logic rise;
	assign rise = slowIn & ~slowPrev_q;
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			slowPrev_q <= 1'b0;
			count_q <= '0;
			tick <= 1'b0;
		end else if (clockEn) begin
			slowPrev_q <= slowIn;
			tick <= 1'b0;
			if (!enable) begin
				count_q <= '0;
			end else if (rise) begin
				if (count_q == CNT_W'(DIVIDE - 1)) begin
					count_q <= '0;
					tick <= 1'b1;
				end else begin
					count_q <= count_q + 1'b1;
				end
			end
		end
	end
endmodule

// ---- logic/timer_half.sv ----
// one 16-bit half: one-shot, periodic, edge count, edge time, pwm
`timescale 1ns/1ps
module timer_half (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic capIn,
	half_ctrl_if.half ctl
);
	gtimer_pkg::half_mode_type mode;
	logic [15:0] value_q;
	logic [15:0] captured_q;
	logic [15:0] valueDec;
	logic enPrev_q;
	logic pinPrev_q;
	logic run;
	logic start;
	logic edgeSeen;
	logic countHit;
	logic zeroHit;
	assign mode = gtimer_pkg::decodeHalf(ctl.modeSel);
	assign run = ctl.enable & ~(ctl.stall & ctl.debugHalt) & ~(ctl.enable & ~enPrev_q);
	assign start = ctl.enable & ~enPrev_q;
	assign valueDec = value_q - 16'h0001;
	assign edgeSeen = (ctl.edgeSel == gtimer_pkg::EDGE_RISE) ? (capIn & ~pinPrev_q) :
		(ctl.edgeSel == gtimer_pkg::EDGE_FALL) ? (~capIn & pinPrev_q) :
		(capIn ^ pinPrev_q);
	assign countHit = edgeSeen & (valueDec == ctl.matchVal);
	assign zeroHit = (mode == gtimer_pkg::HALF_ONE_SHOT) ? (value_q == 16'h0001) :
		(mode == gtimer_pkg::HALF_PERIODIC) & (value_q == 16'h0000);
	assign ctl.shown = (mode == gtimer_pkg::HALF_EDGE_TIME) ? captured_q : value_q;
	// ********************************************************
	// counter
	// ********************************************************
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			value_q <= 16'h0000;
			enPrev_q <= 1'b0;
			pinPrev_q <= 1'b0;
		end else if (ctl.clockEn) begin
			enPrev_q <= ctl.enable;
			pinPrev_q <= capIn;
			if (start) begin
				value_q <= ctl.loadVal;
			end else if (run) begin
				case (mode)
					gtimer_pkg::HALF_ONE_SHOT: begin
						if (value_q != 16'h0000) begin
							value_q <= valueDec;
						end
					end
					gtimer_pkg::HALF_EDGE_COUNT: begin
						if (edgeSeen) begin
							value_q <= countHit ? ctl.loadVal : valueDec;
						end
					end
					default: begin
						value_q <= (value_q == 16'h0000) ? ctl.loadVal : valueDec;
					end
				endcase
			end
		end
	end
	// ********************************************************
	// events, capture, pin
	// ********************************************************
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			captured_q <= 16'h0000;
			ctl.timeout <= 1'b0;
			ctl.capEvent <= 1'b0;
			ctl.capMatch <= 1'b0;
			ctl.trigger <= 1'b0;
			ctl.pinOut <= 1'b0;
			ctl.pinOe <= 1'b0;
		end else if (ctl.clockEn) begin
			ctl.timeout <= run & zeroHit;
			ctl.trigger <= run & zeroHit & ctl.trigEn;
			ctl.capEvent <= run & edgeSeen & ((mode == gtimer_pkg::HALF_EDGE_COUNT) |
				(mode == gtimer_pkg::HALF_EDGE_TIME));
			ctl.capMatch <= run & countHit & (mode == gtimer_pkg::HALF_EDGE_COUNT);
			if (run & edgeSeen & (mode == gtimer_pkg::HALF_EDGE_TIME)) begin
				captured_q <= value_q;
			end
			ctl.pinOe <= (mode == gtimer_pkg::HALF_PWM);
			ctl.pinOut <= ((mode == gtimer_pkg::HALF_PWM) & ctl.enable &
				(value_q > ctl.matchVal)) ^ ctl.invert;
		end
	end
endmodule

// ---- logic/dual_timer.sv ----
// top of the dual 16-bit timer with its wishbone register file
//
// Our own choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
module dual_timer #(
	parameter int unsigned RTC_DIVIDE = gtimer_pkg::RTC_DIVIDE
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic clockEn,
	input wire logic debugHalt,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic irq,
	input wire logic [1:0] capIn,
	output logic [1:0] capOut,
	output logic [1:0] capOe,
	output logic [1:0] trigOut,
	input wire logic rtcClkIn
);
	// ********************************************************
	// declarations
	// ********************************************************
	logic [31:0] cfg_q;
	logic [31:0] halfMode_q;
	logic [31:0] ctrl_q;
	logic [31:0] loadFirst_q;
	logic [31:0] loadSecond_q;
	logic [31:0] matchFirst_q;
	logic [31:0] matchSecond_q;
	logic [31:0] intEnable_q;
	logic [gtimer_pkg::INT_W-1:0] intRaw_q;
	logic [gtimer_pkg::INT_W-1:0] intSet;
	logic [gtimer_pkg::INT_W-1:0] intClr;
	logic [31:0] clrWord;
	logic [31:0] wideValue_q;
	logic wideEnPrev_q;
	logic wideTimeout_q;
	logic rtcMatch_q;
	logic [31:0] readData;
	logic access;
	logic wrStrobe;
	logic rtcTick;
	logic pairMode;
	logic rtcMode;
	logic wideEn;
	logic wideStart;
	logic wideRun;
	logic wideZeroHit;
	gtimer_pkg::top_mode_type topMode;
	half_ctrl_if halfFirst ();
	half_ctrl_if halfSecond ();

	function automatic logic [31:0] applySel(input logic [31:0] old, input logic [31:0] wr,
		input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				res[i*8 +: 8] = wr[i*8 +: 8];
			end
		end
		applySel = res;
	endfunction

	// ********************************************************
	// mode decode
	// ********************************************************
	assign topMode = gtimer_pkg::decodeTop(cfg_q[1:0]);
	assign pairMode = (topMode == gtimer_pkg::CFG_HALF_PAIR);
	assign rtcMode = (topMode == gtimer_pkg::CFG_WIDE_RTC);
	assign wideEn = ~pairMode & ctrl_q[gtimer_pkg::CTL_EN];
	assign wideStart = wideEn & ~wideEnPrev_q;
	assign wideRun = wideEn & ~wideStart &
		~(ctrl_q[gtimer_pkg::CTL_STALL] & debugHalt);
	assign wideZeroHit = (topMode == gtimer_pkg::CFG_WIDE_ONE_SHOT) ?
		(wideValue_q == 32'h0000_0001) :
		((topMode == gtimer_pkg::CFG_WIDE_PERIODIC) & (wideValue_q == 32'h0000_0000));

	// ********************************************************
	// wishbone access
	// ********************************************************
	assign access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wrStrobe = access & wb_we_i;

	always_comb begin
		readData = 32'h0000_0000;
		case (wb_adr_i)
			gtimer_pkg::OFF_CFG: readData = cfg_q;
			gtimer_pkg::OFF_HALF_MODE: readData = halfMode_q;
			gtimer_pkg::OFF_CTRL: readData = ctrl_q;
			gtimer_pkg::OFF_LOAD_FIRST: readData = loadFirst_q;
			gtimer_pkg::OFF_LOAD_SECOND: readData = loadSecond_q;
			gtimer_pkg::OFF_MATCH_FIRST: readData = matchFirst_q;
			gtimer_pkg::OFF_MATCH_SECOND: readData = matchSecond_q;
			gtimer_pkg::OFF_VALUE_FIRST: readData = pairMode ? {16'h0000, halfFirst.shown} :
				wideValue_q;
			gtimer_pkg::OFF_VALUE_SECOND: readData = {16'h0000, halfSecond.shown};
			gtimer_pkg::OFF_INT_RAW: readData = {21'h000000, intRaw_q};
			gtimer_pkg::OFF_INT_MASKED: readData = {21'h000000,
				intRaw_q & intEnable_q[gtimer_pkg::INT_W-1:0]};
			gtimer_pkg::OFF_INT_ENABLE: readData = intEnable_q;
			default: readData = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= gtimer_pkg::RST_WORD;
		end else if (clockEn) begin
			wb_ack_o <= access;
			if (access & ~wb_we_i) begin
				wb_dat_o <= readData;
			end
		end
	end

	// ********************************************************
	// configuration registers
	// ********************************************************
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			cfg_q <= gtimer_pkg::RST_WORD;
			halfMode_q <= gtimer_pkg::RST_WORD;
			ctrl_q <= gtimer_pkg::RST_WORD;
			loadFirst_q <= gtimer_pkg::RST_WORD;
			loadSecond_q <= gtimer_pkg::RST_WORD;
			matchFirst_q <= gtimer_pkg::RST_WORD;
			matchSecond_q <= gtimer_pkg::RST_WORD;
			intEnable_q <= gtimer_pkg::RST_WORD;
		end else if (clockEn & wrStrobe) begin
			case (wb_adr_i)
				gtimer_pkg::OFF_CFG: cfg_q <=
					applySel(cfg_q, wb_dat_i, wb_sel_i) & 32'h0000_0003;
				gtimer_pkg::OFF_HALF_MODE: halfMode_q <=
					applySel(halfMode_q, wb_dat_i, wb_sel_i) & 32'h0000_0077;
				gtimer_pkg::OFF_CTRL: ctrl_q <=
					applySel(ctrl_q, wb_dat_i, wb_sel_i) & 32'h0001_3F3F;
				gtimer_pkg::OFF_LOAD_FIRST: loadFirst_q <=
					applySel(loadFirst_q, wb_dat_i, wb_sel_i);
				gtimer_pkg::OFF_LOAD_SECOND: loadSecond_q <=
					applySel(loadSecond_q, wb_dat_i, wb_sel_i) & 32'h0000_FFFF;
				gtimer_pkg::OFF_MATCH_FIRST: matchFirst_q <=
					applySel(matchFirst_q, wb_dat_i, wb_sel_i);
				gtimer_pkg::OFF_MATCH_SECOND: matchSecond_q <=
					applySel(matchSecond_q, wb_dat_i, wb_sel_i) & 32'h0000_FFFF;
				gtimer_pkg::OFF_INT_ENABLE: intEnable_q <=
					applySel(intEnable_q, wb_dat_i, wb_sel_i) & 32'h0000_070F;
				default: cfg_q <= cfg_q;
			endcase
		end
	end

	// ********************************************************
	// joined 32-bit counter and clock
	// ********************************************************
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			wideValue_q <= 32'h0000_0000;
			wideEnPrev_q <= 1'b0;
			wideTimeout_q <= 1'b0;
			rtcMatch_q <= 1'b0;
		end else if (clockEn) begin
			wideEnPrev_q <= wideEn;
			wideTimeout_q <= wideRun & wideZeroHit;
			rtcMatch_q <= wideRun & rtcMode & rtcTick &
				(wideValue_q + 32'h0000_0001 == matchFirst_q);
			if (wideStart) begin
				wideValue_q <= loadFirst_q;
			end else if (wideRun) begin
				case (topMode)
					gtimer_pkg::CFG_WIDE_ONE_SHOT: begin
						if (wideValue_q != 32'h0000_0000) begin
							wideValue_q <= wideValue_q - 32'h0000_0001;
						end
					end
					gtimer_pkg::CFG_WIDE_PERIODIC: begin
						wideValue_q <= (wideValue_q == 32'h0000_0000) ? loadFirst_q :
							wideValue_q - 32'h0000_0001;
					end
					gtimer_pkg::CFG_WIDE_RTC: begin
						if (rtcTick) begin
							wideValue_q <= wideValue_q + 32'h0000_0001;
						end
					end
					default: wideValue_q <= wideValue_q;
				endcase
			end
		end
	end

	rtc_prescaler #(
		.DIVIDE(RTC_DIVIDE)
	) u_prescaler (
		.clock(clock),
		.sys_rst(sys_rst),
		.clockEn(clockEn),
		.enable(rtcMode & ctrl_q[gtimer_pkg::CTL_RTC_EN]),
		.slowIn(rtcClkIn),
		.tick(rtcTick)
	);

	// ********************************************************
	// the two halves
	// ********************************************************
	assign halfFirst.clockEn = clockEn;
	assign halfFirst.debugHalt = debugHalt;
	assign halfFirst.modeSel = pairMode ? halfMode_q[2:0] : 3'h0;
	assign halfFirst.enable = pairMode & ctrl_q[gtimer_pkg::CTL_EN];
	assign halfFirst.invert = ctrl_q[gtimer_pkg::CTL_INV];
	assign halfFirst.stall = ctrl_q[gtimer_pkg::CTL_STALL];
	assign halfFirst.trigEn = ctrl_q[gtimer_pkg::CTL_TRIG];
	assign halfFirst.edgeSel = ctrl_q[gtimer_pkg::CTL_EDGE_LO +: 2];
	assign halfFirst.loadVal = loadFirst_q[15:0];
	assign halfFirst.matchVal = matchFirst_q[15:0];

	assign halfSecond.clockEn = clockEn;
	assign halfSecond.debugHalt = debugHalt;
	assign halfSecond.modeSel = pairMode ?
		halfMode_q[gtimer_pkg::HALF_MODE_SECOND_LO +: 3] : 3'h0;
	assign halfSecond.enable = pairMode &
		ctrl_q[gtimer_pkg::CTL_STRIDE + gtimer_pkg::CTL_EN];
	assign halfSecond.invert = ctrl_q[gtimer_pkg::CTL_STRIDE + gtimer_pkg::CTL_INV];
	assign halfSecond.stall = ctrl_q[gtimer_pkg::CTL_STRIDE + gtimer_pkg::CTL_STALL];
	assign halfSecond.trigEn = ctrl_q[gtimer_pkg::CTL_STRIDE + gtimer_pkg::CTL_TRIG];
	assign halfSecond.edgeSel = ctrl_q[gtimer_pkg::CTL_STRIDE + gtimer_pkg::CTL_EDGE_LO +: 2];
	assign halfSecond.loadVal = loadSecond_q[15:0];
	assign halfSecond.matchVal = matchSecond_q[15:0];

	timer_half u_first (
		.clock(clock),
		.sys_rst(sys_rst),
		.capIn(capIn[0]),
		.ctl(halfFirst.half)
	);

	timer_half u_second (
		.clock(clock),
		.sys_rst(sys_rst),
		.capIn(capIn[1]),
		.ctl(halfSecond.half)
	);

	assign capOut = {halfSecond.pinOut, halfFirst.pinOut};
	assign capOe = {halfSecond.pinOe, halfFirst.pinOe};

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			trigOut <= 2'h0;
		end else if (clockEn) begin
			trigOut[0] <= pairMode ? halfFirst.trigger :
				(wideRun & wideZeroHit & ctrl_q[gtimer_pkg::CTL_TRIG]);
			trigOut[1] <= halfSecond.trigger;
		end
	end

	// ********************************************************
	// interrupts
	// ********************************************************
	always_comb begin
		intSet = '0;
		intSet[gtimer_pkg::INT_TIMEOUT] = pairMode ? halfFirst.timeout : wideTimeout_q;
		intSet[gtimer_pkg::INT_CAP_MATCH] = halfFirst.capMatch;
		intSet[gtimer_pkg::INT_CAP_EVENT] = halfFirst.capEvent;
		intSet[gtimer_pkg::INT_RTC_MATCH] = rtcMatch_q;
		intSet[gtimer_pkg::INT_STRIDE + gtimer_pkg::INT_TIMEOUT] = halfSecond.timeout;
		intSet[gtimer_pkg::INT_STRIDE + gtimer_pkg::INT_CAP_MATCH] = halfSecond.capMatch;
		intSet[gtimer_pkg::INT_STRIDE + gtimer_pkg::INT_CAP_EVENT] = halfSecond.capEvent;
	end

	assign clrWord = applySel(32'h0000_0000, wb_dat_i, wb_sel_i);
	assign intClr = (wrStrobe & (wb_adr_i == gtimer_pkg::OFF_INT_CLEAR)) ?
		clrWord[gtimer_pkg::INT_W-1:0] : '0;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			intRaw_q <= '0;
			irq <= 1'b0;
		end else if (clockEn) begin
			intRaw_q <= (intRaw_q & ~intClr) | intSet;
			irq <= |(intRaw_q & intEnable_q[gtimer_pkg::INT_W-1:0]);
		end
	end
endmodule

// ---- dv/dual_timer_checker.sv ----
// port assertions for the dual timer top
`timescale 1ns/1ps
module dual_timer_checker (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic clockEn,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic irq,
	input wire logic [1:0] capOut,
	input wire logic [1:0] capOe,
	input wire logic [1:0] trigOut
);
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	property p_ack_late;
		wb_cyc_i && wb_stb_i && !wb_ack_o && clockEn |=> wb_ack_o;
	endproperty
	a_ack_late: assert property (p_ack_late) else $error("no ack after request");
	property p_ack_drop;
		wb_ack_o && clockEn |=> !wb_ack_o;
	endproperty
	a_ack_drop: assert property (p_ack_drop) else $error("ack longer than one cycle");
	property p_ack_cause;
		$rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i);
	endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
	property p_dat_hold;
		$changed(wb_dat_o) |-> wb_ack_o;
	endproperty
	a_dat_hold: assert property (p_dat_hold) else $error("read data moved without ack");
	property p_irq_clear;
		$fell(irq) |-> $past(wb_ack_o && wb_we_i && (wb_adr_i == 8'h30 || wb_adr_i == 8'h2C));
	endproperty
	a_irq_clear: assert property (p_irq_clear) else $error("irq fell without clear");
	property p_oe_cause;
		$changed(capOe) |-> $past(wb_ack_o && wb_we_i) || (wb_ack_o && wb_we_i);
	endproperty
	a_oe_cause: assert property (p_oe_cause) else $error("pin enable moved alone");
	property p_out_owned;
		$changed(capOut[0]) |-> capOe[0] || $past(capOe[0]);
	endproperty
	a_out_owned: assert property (p_out_owned) else $error("pin drive without enable");
	property p_freeze;
		!clockEn |=> $stable(wb_ack_o) && $stable(trigOut) && $stable(irq);
	endproperty
	a_freeze: assert property (p_freeze) else $error("outputs moved while frozen");
endmodule
bind dual_timer dual_timer_checker chk (.clock, .sys_rst, .clockEn, .wb_cyc_i, .wb_stb_i,
	.wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .irq, .capOut, .capOe, .trigOut);

// ---- dv/cap_pins_model.sv ----
// far side of the two capture pins
`timescale 1ns/1ps
module cap_pins_model (
	input wire logic clock,
	input wire logic [1:0] capOut,
	input wire logic [1:0] capOe,
	output logic [1:0] capIn
);
	logic [1:0] lvl = 2'h0;
	// design drive wins while its enable is high
	assign capIn = (capOe & capOut) | (~capOe & lvl);
	// full pulses give one rising and one falling edge each
	task automatic pulses(input int h, input int n);
		repeat (n) begin
			repeat (4) @(posedge clock);
			lvl[h] <= 1'b1;
			repeat (4) @(posedge clock);
			lvl[h] <= 1'b0;
		end
		repeat (8) @(posedge clock);
	endtask
endmodule

// ---- dv/dual_timer_test.sv ----
// self-checking bench for the dual timer
`timescale 1ns/1ps
module dual_timer_test;
	typedef struct packed {logic [7:0] a; logic [31:0] v;} note_type;
	logic clock = 1'b0, sys_rst = 1'b1, clockEn = 1'b0, debugHalt = 1'b0, rtcClk = 1'b0;
	logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, ack, irq;
	logic [7:0] wbAdr = 8'h00;
	logic [3:0] wbSel = 4'h0;
	logic [31:0] wbDat = 32'h0, rdat, r;
	logic [1:0] capIn, capOut, capOe, trigOut;
	int failCount = 0, checksDone = 0, ticks = 0, c, hi, tr, ld;
	note_type notes[$];
	note_type n;
	dual_timer #(.RTC_DIVIDE(4)) DUT (.clock(clock), .sys_rst(sys_rst), .clockEn(clockEn),
		.debugHalt(debugHalt), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
		.wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.irq(irq), .capIn(capIn), .capOut(capOut), .capOe(capOe), .trigOut(trigOut),
		.rtcClkIn(rtcClk));
	cap_pins_model pins (.clock(clock), .capOut(capOut), .capOe(capOe), .capIn(capIn));
	initial forever #25 clock = ~clock;
	task automatic reportAndStop();
		$display("checks %0d mismatches %0d", checksDone, failCount);
		if (failCount == 0 && checksDone > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// slow input near 32 kHz, plus the hang limit
	always @(posedge clock) begin
		ticks <= ticks + 1;
		if (ticks % 305 == 0) rtcClk <= ~rtcClk;
		if (ticks == 30000) begin
			failCount++;
			reportAndStop();
		end
	end
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checksDone++;
		if (seen !== exp) begin
			failCount++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// read answers meet the oldest note
	always @(posedge clock) begin
		if (ack === 1'b1 && wbWe === 1'b0 && notes.size() > 0) begin
			n = notes.pop_front();
			check($sformatf("reg %h", n.a), rdat, n.v);
		end
	end
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge clock);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= w;
		wbAdr <= a;
		wbSel <= 4'hF;
		wbDat <= d;
		do @(posedge clock); while (ack !== 1'b1);
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		wbWe <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(a, 1'b1, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] v);
		notes.push_back({a, v});
		bus(a, 1'b0, 32'h0);
	endtask
	task automatic waitIrq(input int lim, output int k);
		repeat (2) @(posedge clock);
		k = 2;
		while (irq !== 1'b1 && k < lim) begin
			@(posedge clock);
			k++;
		end
	endtask
	task automatic tally(output int h, output int t);
		h = 0;
		t = 0;
		repeat (100) begin
			@(posedge clock);
			h += (capOut[0] === 1'b1);
			t += (trigOut[1] === 1'b1);
		end
	endtask
	initial begin
		void'($urandom(63943));
		repeat (8) @(posedge clock);
		sys_rst <= 1'b0;
		repeat (3) @(posedge clock);
		clockEn <= 1'b1;
		wr(8'h24, 32'hFFFF_FFFF);
		rd(8'h24, gtimer_pkg::RST_WORD);
		rd(8'h08, gtimer_pkg::RST_WORD);
		rd(8'h3C, 32'h0);
		r = $urandom();
		wr(8'h10, r);
		rd(8'h10, r & 32'hFFFF);
		ld = $urandom_range(40, 8);
		wr(8'h0C, ld);
		wr(8'h2C, 32'h1);
		wr(8'h08, 32'h1);
		waitIrq(ld + 8, c);
		check("one-shot delay", c >= ld && c < ld + 8, 1);
		repeat (10) @(posedge clock);
		rd(8'h1C, 32'h0);
		rd(8'h28, 32'h1);
		wr(8'h30, 32'h1);
		rd(8'h24, 32'h0);
		check("irq cleared", irq, 0);
		wr(8'h08, 32'h0);
		wr(8'h00, 32'h1);
		wr(8'h08, 32'h9);
		repeat (2) begin
			waitIrq(ld + 8, c);
			check("periodic irq", irq, 1);
			wr(8'h30, 32'h1);
		end
		wr(8'h2C, 32'h0);
		tr = 0;
		repeat (2 * ld + 4) begin
			@(posedge clock);
			tr += (trigOut[0] === 1'b1);
		end
		check("wide trigger", tr >= 2 && tr <= 3, 1);
		check("masked irq", irq, 0);
		rd(8'h24, 32'h1);
		rd(8'h28, 32'h0);
		wr(8'h08, 32'h0);
		for (int m = 0; m < 5; m++) begin
			wr(8'h04, m | m << 4);
			rd(8'h04, m | m << 4);
		end
		wr(8'h00, 32'h3);
		wr(8'h04, 32'h14);
		wr(8'h0C, 32'h9);
		wr(8'h14, 32'h2);
		wr(8'h10, 32'h9);
		for (int i = 0; i < 3; i++) begin
			wr(8'h08, i > 0 ? 32'h0D03 : 32'h0D01);
			debugHalt <= (i == 2);
			repeat (4) @(posedge clock);
			tally(hi, tr);
			check("pwm enable", capOe, 2'h1);
			check("pwm high", hi, i > 0 ? 30 : 70);
			check("trigger count", tr, i == 2 ? 0 : 10);
		end
		debugHalt <= 1'b0;
		wr(8'h08, 32'h0);
		wr(8'h04, 32'h32);
		wr(8'h0C, 32'h14);
		wr(8'h14, 32'h10);
		wr(8'h10, 32'hFFFF);
		for (int e = 0; e < 3; e++) begin
			wr(8'h08, e << 4);
			wr(8'h30, 32'h7FF);
			wr(8'h08, 32'h101 | e << 4);
			pins.pulses(0, 2);
			rd(8'h1C, e == 2 ? 32'h14 : 32'h12);
			rd(8'h24, e == 2 ? 32'h6 : 32'h4);
		end
		wr(8'h30, 32'h7FF);
		pins.pulses(1, 1);
		rd(8'h24, 32'h400);
		wr(8'h08, 32'h0);
		wr(8'h00, 32'h2);
		wr(8'h0C, 32'h0);
		wr(8'h14, 32'h3);
		wr(8'h30, 32'h7FF);
		wr(8'h2C, 32'h8);
		wr(8'h08, 32'h10001);
		waitIrq(9000, c);
		check("clock match delay", c > 4800 && irq === 1'b1, 1);
		rd(8'h1C, 32'h3);
		rd(8'h28, 32'h8);
		repeat (2) @(posedge clock);
		reportAndStop();
	end
endmodule
